// ---- rtl/timer_pkg.sv ----
// Constants and types shared by the compact timer design
package timer_pkg;
    localparam int CNT_W = 10;
    localparam int ADDR_W = 4;
    // Register indices
    localparam logic [3:0] REG_RUN = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h1;
    localparam logic [3:0] REG_CNT_LO = 4'h2;
    localparam logic [3:0] REG_CNT_HI = 4'h3;
    localparam logic [3:0] REG_CMPA_LO = 4'h4;
    localparam logic [3:0] REG_CMPA_HI = 4'h5;
    localparam logic [3:0] REG_CMPP = 4'h6;
    localparam logic [3:0] REG_FLAGS = 4'h7;
    // Field positions
    localparam int RUN_BIT = 3;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [9:0] CMPA_RST = 10'h000;
    localparam logic [2:0] CMPP_RST = 3'h0;
    // Comparator P acts on the top bits of the counter
    localparam int P_SHIFT = 7;
    localparam logic [10:0] FULL_SPAN = 11'h400;
    // Operating modes
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    // Pin actions
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    typedef struct packed {
        logic [1:0] op_mode_select;
        logic [1:0] pin_action_select;
        logic initial_level_select;
        logic output_invert;
        logic period_duty_swap;
        logic clear_source_select;
    } ctrl_type;

    typedef struct packed {
        logic run_rise;
        logic match_a;
        logic pwm_active;
    } pin_event_type;
endpackage

// ---- rtl/pin_driver.sv ----
// Output pin state and shaping for the compact timer
`timescale 1ns/10ps
module pin_driver (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Setup and events
    input timer_pkg::ctrl_type ctrl,
    input timer_pkg::pin_event_type ev,
    // Pin
    output logic pin_out,
    output logic pin_oe
);
    import timer_pkg::*;

    logic level_ff;
    logic nxt_level;
    logic pin_ff;
    logic nxt_pin;
    logic oe_ff;
    logic nxt_oe;
    logic pwm_level;

    always_comb begin
        nxt_level = level_ff;
        if (ev.run_rise) begin
            nxt_level = ctrl.initial_level_select;
        end else if (ev.match_a) begin
            // Only comparator A moves the pin; P never reaches here
            case (ctrl.pin_action_select)
                ACT_LOW: nxt_level = 1'b0;
                ACT_HIGH: nxt_level = 1'b1;
                ACT_TOGGLE: nxt_level = ~level_ff;
                default: nxt_level = level_ff;
            endcase
        end
        // Active level follows the selected polarity
        case (ctrl.pin_action_select)
            ACT_NONE: pwm_level = ~ctrl.initial_level_select;
            ACT_LOW: pwm_level = ctrl.initial_level_select;
            ACT_HIGH: pwm_level = ev.pwm_active ? ctrl.initial_level_select
                                                : ~ctrl.initial_level_select;
            default: pwm_level = ~ctrl.initial_level_select;
        endcase
        nxt_oe = 1'b0;
        nxt_pin = 1'b0;
        if (ctrl.op_mode_select == MODE_COMPARE) begin
            nxt_oe = 1'b1;
            nxt_pin = nxt_level ^ ctrl.output_invert;
        end else if (ctrl.op_mode_select == MODE_PWM) begin
            nxt_oe = 1'b1;
            nxt_pin = pwm_level ^ ctrl.output_invert;
        end
        // Timer mode releases the pin for other uses
        if (ctrl.op_mode_select == MODE_TIMER) begin
            nxt_oe = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            level_ff <= 1'b0;
            pin_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            level_ff <= nxt_level;
            pin_ff <= nxt_pin;
            oe_ff <= nxt_oe;
        end
    end

    assign pin_out = pin_ff;
    assign pin_oe = oe_ff;
endmodule // pin_driver

// ---- rtl/compact_timer.sv ----
// Compact 10-bit timer with compare, timer and PWM modes
// Notes on behaviour
// - Compare mode: pin moves only on A match or run rising edge
// - P match never touches the pin
// - Pin action zero: no change on A
// - Run rising edge loads the initial pin level
// - Timer mode counts like compare, pin released
// - Clear source zero clears on P match
// - Clear source one clears on A match
// - Clear source one suppresses the P flag
// - PWM mode ignores the clear source
// - Swap picks which comparator sets period
// - P code n gives n*128, zero 1024
// - Swapped: A period, P code duty
// - Duty at or above period: always active
// - PWM raises both flags on their matches
// - Level select sets polarity; action selects waveform
// - Invert flips the pin waveform
// - Counting continues while pin is forced
// - Mode zero is compare match output
// - Actions 01/10/11: low, high, toggle
// - PWM actions: inactive, active, waveform
// - P code matches the counter's top bits
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module compact_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Timer clock tick from the clock selector
    input wire logic timer_tick,
    // Register port
    input wire logic [timer_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Output pin
    output logic pin_out,
    output logic pin_oe,
    // Flags
    output logic match_a_flag,
    output logic match_p_flag
);
    import timer_pkg::*;

    ctrl_type ctrl_ff;
    ctrl_type nxt_ctrl;
    logic run_enable_ff;
    logic nxt_run_enable;
    logic run_prev_ff;
    logic [9:0] cmpa_ff;
    logic [9:0] nxt_cmpa;
    logic [2:0] cmpp_ff;
    logic [2:0] nxt_cmpp;
    logic [9:0] cnt_ff;
    logic [9:0] nxt_cnt;
    logic flag_a_ff;
    logic nxt_flag_a;
    logic flag_p_ff;
    logic nxt_flag_p;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    logic run_rise;
    logic step;
    logic [10:0] cnt_inc;
    logic [10:0] p_span;
    logic [10:0] a_span;
    logic [10:0] period;
    logic [10:0] duty;
    logic hit_a;
    logic hit_p;
    logic is_pwm;
    logic clr;
    logic pwm_active;
    pin_event_type ev;

    assign run_rise = run_enable_ff & ~run_prev_ff;
    // The restart cycle does not count, so the first tick sees zero
    assign step = run_enable_ff & timer_tick & ~run_rise;
    assign cnt_inc = {1'b0, cnt_ff} + 11'h001;
    // Code zero stands for the full span of the counter
    assign p_span = (cmpp_ff == 3'h0) ? FULL_SPAN
                                      : {1'b0, cmpp_ff, 7'h00};
    assign a_span = {1'b0, cmpa_ff};
    assign hit_p = step && (cnt_inc[10:P_SHIFT] == p_span[10:P_SHIFT])
                   && (cnt_inc[P_SHIFT-1:0] == 7'h00);
    // A zero compare A lets the counter roll over without a flag
    assign hit_a = step && (cmpa_ff != CMPA_RST) && (cnt_inc == a_span);
    assign is_pwm = (ctrl_ff.op_mode_select == MODE_PWM);

    always_comb begin
        if (is_pwm) begin
            // Clear source plays no part here
            clr = ctrl_ff.period_duty_swap ? hit_a : hit_p;
            period = ctrl_ff.period_duty_swap ? a_span : p_span;
            duty = ctrl_ff.period_duty_swap ? p_span : a_span;
        end else begin
            clr = ctrl_ff.clear_source_select ? hit_a : hit_p;
            period = FULL_SPAN;
            duty = 11'h000;
        end
        // Counting runs on whatever the pin action is
        pwm_active = ({1'b0, cnt_ff} < duty) || (duty >= period);
    end

    assign ev.run_rise = run_rise;
    assign ev.match_a = hit_a & ~is_pwm;
    assign ev.pwm_active = pwm_active;

    // Counter
    always_comb begin
        nxt_cnt = cnt_ff;
        if (run_rise) begin
            nxt_cnt = 10'h000;
        end else if (step) begin
            nxt_cnt = clr ? 10'h000 : cnt_inc[9:0];
        end
    end

    // Flags: a new match beats a clear in the same cycle
    always_comb begin
        nxt_flag_a = flag_a_ff;
        nxt_flag_p = flag_p_ff;
        if (reg_wr && reg_addr == REG_FLAGS) begin
            if (reg_wdata[FLAG_A_BIT]) begin
                nxt_flag_a = 1'b0;
            end
            if (reg_wdata[FLAG_P_BIT]) begin
                nxt_flag_p = 1'b0;
            end
        end
        if (hit_a) begin
            nxt_flag_a = 1'b1;
        end
        if (hit_p && (is_pwm || !ctrl_ff.clear_source_select)) begin
            nxt_flag_p = 1'b1;
        end
    end

    // Register writes and reads
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_run_enable = run_enable_ff;
        nxt_cmpa = cmpa_ff;
        nxt_cmpp = cmpp_ff;
        nxt_rdata = 8'h00;
        if (reg_wr) begin
            if (reg_addr == REG_RUN) begin
                nxt_run_enable = reg_wdata[RUN_BIT];
            end else if (reg_addr == REG_CTRL) begin
                nxt_ctrl = ctrl_type'(reg_wdata);
            end else if (reg_addr == REG_CMPA_LO) begin
                nxt_cmpa[7:0] = reg_wdata;
            end else if (reg_addr == REG_CMPA_HI) begin
                nxt_cmpa[9:8] = reg_wdata[1:0];
            end else if (reg_addr == REG_CMPP) begin
                nxt_cmpp = reg_wdata[2:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == REG_RUN) begin
                nxt_rdata = {4'h0, run_enable_ff, 3'h0};
            end else if (reg_addr == REG_CTRL) begin
                nxt_rdata = ctrl_ff;
            end else if (reg_addr == REG_CNT_LO) begin
                nxt_rdata = cnt_ff[7:0];
            end else if (reg_addr == REG_CNT_HI) begin
                nxt_rdata = {6'h00, cnt_ff[9:8]};
            end else if (reg_addr == REG_CMPA_LO) begin
                nxt_rdata = cmpa_ff[7:0];
            end else if (reg_addr == REG_CMPA_HI) begin
                nxt_rdata = {6'h00, cmpa_ff[9:8]};
            end else if (reg_addr == REG_CMPP) begin
                nxt_rdata = {5'h00, cmpp_ff};
            end else if (reg_addr == REG_FLAGS) begin
                nxt_rdata = {6'h00, flag_p_ff, flag_a_ff};
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff <= ctrl_type'(CTRL_RST);
            run_enable_ff <= 1'b0;
            run_prev_ff <= 1'b0;
            cmpa_ff <= CMPA_RST;
            cmpp_ff <= CMPP_RST;
            cnt_ff <= 10'h000;
            flag_a_ff <= 1'b0;
            flag_p_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ctrl_ff <= nxt_ctrl;
            run_enable_ff <= nxt_run_enable;
            run_prev_ff <= run_enable_ff;
            cmpa_ff <= nxt_cmpa;
            cmpp_ff <= nxt_cmpp;
            cnt_ff <= nxt_cnt;
            flag_a_ff <= nxt_flag_a;
            flag_p_ff <= nxt_flag_p;
            rdata_ff <= nxt_rdata;
        end
    end

    pin_driver u_pin (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .ctrl(ctrl_ff),
        .ev(ev),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    assign reg_rdata = rdata_ff;
    assign match_a_flag = flag_a_ff;
    assign match_p_flag = flag_p_ff;
endmodule // compact_timer

// ---- verification/compact_timer_props.sv ----
// Port checker for the compact timer
`timescale 1ns/10ps
module compact_timer_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Register port and tick
    input wire logic timer_tick,
    input wire logic [timer_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pin and flags
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic match_a_flag,
    input wire logic match_p_flag
);
    import timer_pkg::*;
    ctrl_type ctl_ff;
    logic run_ff;
    logic [2:0] age_ff;
    logic [1:0] mode;
    logic [1:0] act;
    logic lvl;
    logic clr_a;
    logic clr_p;
    logic go;
    assign mode = ctl_ff.op_mode_select;
    assign act = ctl_ff.pin_action_select;
    assign lvl = ctl_ff.initial_level_select ^ ctl_ff.output_invert;
    assign clr_a = reg_wr && reg_addr == REG_FLAGS && reg_wdata[FLAG_A_BIT];
    assign clr_p = reg_wr && reg_addr == REG_FLAGS && reg_wdata[FLAG_P_BIT];
    assign go = reg_wr && reg_addr == REG_RUN && reg_wdata[RUN_BIT] && !run_ff;
    // Shadow of setup; age keeps checks clear of the restart reload
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_ff <= ctrl_type'(CTRL_RST);
            run_ff <= 1'b0;
            age_ff <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == REG_CTRL) ctl_ff <= ctrl_type'(reg_wdata);
            if (reg_wr && reg_addr == REG_RUN) run_ff <= reg_wdata[RUN_BIT];
            age_ff <= !run_ff ? 3'h0 : (age_ff == 3'h7 ? age_ff : age_ff + 3'h1);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    AST_A_STICKY: assert property (match_a_flag && !clr_a |=> match_a_flag)
        else $error("flag A dropped without a clear");
    AST_P_STICKY: assert property (match_p_flag && !clr_p |=> match_p_flag)
        else $error("flag P dropped without a clear");
    AST_P_SUPPRESS: assert property (ctl_ff.clear_source_select && mode != MODE_PWM
        && !match_p_flag |=> !match_p_flag) else $error("flag P set with clear on A");
    AST_TIMER_OE: assert property (mode == MODE_TIMER && $past(mode) == MODE_TIMER
        |-> !pin_oe) else $error("pin driven in timer mode");
    AST_RUN_LEVEL: assert property (go && mode == MODE_COMPARE
        |-> ##2 pin_out == lvl) else $error("pin not at initial level after start");
    // Flag is sticky, so a pin move must find it already set when seen
    AST_PIN_BY_A: assert property (mode == MODE_COMPARE && age_ff == 3'h7
        && $changed(pin_out) |-> match_a_flag) else $error("pin moved without A");
    AST_HOLD_NONE: assert property (mode == MODE_COMPARE && act == ACT_NONE
        && age_ff == 3'h7 |-> $stable(pin_out)) else $error("pin moved with no action");
    AST_PWM_FORCE: assert property (mode == MODE_PWM && !act[1] && age_ff == 3'h7
        |-> pin_out == (lvl ^ (act == ACT_NONE))) else $error("forced PWM level wrong");
endmodule // compact_timer_props
bind compact_timer compact_timer_props u_compact_timer_props (
    .core_clk(core_clk), .arst_n(arst_n), .timer_tick(timer_tick), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_out(pin_out), .pin_oe(pin_oe), .match_a_flag(match_a_flag),
    .match_p_flag(match_p_flag)
);

// ---- verification/compact_timer_bench.sv ----
// Self-checking bench for the compact timer
`timescale 1ns/10ps
module compact_timer_bench;
    import timer_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic timer_tick = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic pin_out, pin_oe, match_a_flag, match_p_flag;
    logic [7:0] rv, rv2;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    compact_timer u_compact_timer (.core_clk(core_clk), .arst_n(arst_n),
        .timer_tick(timer_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_out(pin_out),
        .pin_oe(pin_oe), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
    initial forever #12.5 core_clk = ~core_clk;
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run needs about 10000 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Strobe drops for a cycle so no signal is set twice in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask
    task automatic wait_flag(input logic p);
        repeat (300) if ((p ? match_p_flag : match_a_flag) !== 1'b1) @(posedge core_clk);
        chk("flag wait", 1'b1, p ? match_p_flag : match_a_flag);
    endtask
    task automatic setup(input logic [7:0] c, input logic [9:0] a, input logic [2:0] p);
        wr(REG_RUN, 8'h00);
        wr(REG_FLAGS, 8'h03);
        wr(REG_CTRL, c);
        wr(REG_CMPA_LO, a[7:0]);
        wr(REG_CMPA_HI, {6'h00, a[9:8]});
        wr(REG_CMPP, {5'h00, p});
        wr(REG_RUN, 8'h08);
    endtask
    task automatic t_regs;
        rd(REG_CTRL, rv);
        chk("ctrl reset", CTRL_RST, rv);
        wr(4'h9, 8'hFF);
        rd(4'h9, rv);
        chk("unmapped", 8'h00, rv);
        wr(REG_CMPP, 8'hFF);
        rd(REG_CMPP, rv);
        chk("cmpp width", 8'h07, rv);
        $display("t_regs done");
    endtask
    task automatic t_compare;
        logic [1:0] act;
        logic init;
        for (int k = 0; k < 4; k++) begin
            act = k[1:0];
            init = (act == ACT_NONE || act == ACT_LOW);
            setup({MODE_COMPARE, act, init, 3'h1}, 10'h014, 3'h0);
            repeat (3) @(posedge core_clk);
            chk("pin init", init, pin_out);
            chk("pin oe", 1'b1, pin_oe);
            wait_flag(1'b0);
            repeat (2) @(posedge core_clk);
            chk("pin action", act != ACT_LOW, pin_out);
            rd(REG_CNT_LO, rv);
            chk("cnt below A", 1'b1, rv < 8'h14);
            chk("flag p", 1'b0, match_p_flag);
        end
        setup({MODE_TIMER, ACT_HIGH, 1'b0, 3'h1}, 10'h014, 3'h0);
        wait_flag(1'b0);
        chk("timer oe", 1'b0, pin_oe);
        $display("t_compare done");
    endtask
    task automatic t_clear_p;
        setup({MODE_COMPARE, ACT_NONE, 1'b0, 3'h0}, 10'h005, 3'h1);
        wait_flag(1'b1);
        chk("flag a", 1'b1, match_a_flag);
        // P clear landed two edges before the read strobe is taken
        rd(REG_CNT_LO, rv);
        chk("cnt after P", 8'h01, rv);
        wr(REG_RUN, 8'h00);
        rd(REG_CNT_LO, rv);
        rd(REG_CNT_LO, rv2);
        chk("cnt hold", rv, rv2);
        wr(REG_FLAGS, 8'h01);
        chk("clear a", 2'h2, {match_p_flag, match_a_flag});
        $display("t_clear_p done");
    endtask
    task automatic t_tick;
        timer_tick <= 1'b0;
        setup({MODE_COMPARE, ACT_NONE, 1'b0, 3'h1}, 10'h014, 3'h0);
        repeat (4) @(posedge core_clk);
        rd(REG_CNT_LO, rv);
        chk("cnt no tick", 8'h00, rv);
        repeat (5) begin
            timer_tick <= 1'b1;
            @(posedge core_clk);
            timer_tick <= 1'b0;
            @(posedge core_clk);
        end
        rd(REG_CNT_LO, rv);
        chk("cnt per tick", 8'h05, rv);
        timer_tick <= 1'b1;
        $display("t_tick done");
    endtask
    task automatic t_pwm;
        logic [7:0] pc [9] = '{8'hA8, 8'hAC, 8'hA1, 8'hAA, 8'hA8, 8'h98, 8'h88, 8'hA8, 8'hAA};
        logic [9:0] pa [9] = '{10'h020, 10'h020, 10'h020, 10'h200, 10'h0C8, 10'h020, 10'h020,
            10'h100, 10'h200};
        // Code zero spans the whole counter; code three is a swapped duty
        logic [2:0] pp [9] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h3};
        int pw [9] = '{256, 256, 256, 512, 256, 256, 256, 1024, 512};
        int ph [9] = '{64, 192, 192, 128, 256, 256, 0, 256, 384};
        int hi;
        for (int k = 0; k < 9; k++) begin
            setup(pc[k], pa[k], pp[k]);
            repeat (600) @(posedge core_clk);
            hi = 0;
            repeat (pw[k]) begin
                @(posedge core_clk);
                hi += (pin_out === 1'b1);
            end
            chk("pwm high", ph[k], hi);
            chk("pwm flag p", 1'b1, match_p_flag);
            chk("pwm flag a", k != 4, match_a_flag);
        end
        $display("t_pwm done");
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_compare();
        t_clear_p();
        t_tick();
        t_pwm();
        finish_test();
    end
endmodule // compact_timer_bench
